/* design/timer16_pkg.sv */
// Constants, register map and bus carriers for the 16-bit timer/counter.
// Assumes an APB master with 32-bit data; each 8-bit register sits in the low byte of a word.
`default_nettype none
package timer16_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS = 8'h36;
	localparam logic [7:0] IDX_MASK = 8'h6F;
	localparam logic [7:0] IDX_CTRL_A = 8'h80;
	localparam logic [7:0] IDX_CTRL_B = 8'h81;
	localparam logic [7:0] IDX_CTRL_C = 8'h82;
	localparam logic [7:0] IDX_CNT_L = 8'h84;
	localparam logic [7:0] IDX_CNT_H = 8'h85;
	localparam logic [7:0] IDX_CAP_L = 8'h86;
	localparam logic [7:0] IDX_CAP_H = 8'h87;
	localparam logic [7:0] IDX_CMPA_L = 8'h88;
	localparam logic [7:0] IDX_CMPA_H = 8'h89;
	localparam logic [7:0] IDX_CMPB_L = 8'h8A;
	localparam logic [7:0] IDX_CMPB_H = 8'h8B;
	// Field positions
	localparam int B_NF = 7;
	localparam int B_CES = 6;
	localparam int B_FOCA = 7;
	localparam int B_FOCB = 6;
	localparam int B_CAP = 5;
	localparam int B_CMPB = 2;
	localparam int B_CMPA = 1;
	localparam int B_OVF = 0;
	// Writable/readable masks; everything else reads zero
	localparam logic [7:0] CTRL_A_MASK = 8'hF3;
	localparam logic [7:0] CTRL_B_MASK = 8'hDF;
	localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// Prescaler tap masks: tick when the free-running count has all these bits set
	localparam logic [9:0] DIV8_MASK = 10'h007;
	localparam logic [9:0] DIV64_MASK = 10'h03F;
	localparam logic [9:0] DIV256_MASK = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;
	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Extra delay of the capture filter, in mclk_i cycles
	localparam int FILTER_DELAY = 4;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage
`default_nettype wire

/* design/timer16.sv */
// 16-bit timer/counter with prescaled or external count clock, capture, two compare channels.
// Assumes an APB master on mclk_i; capture and count pins are asynchronous and are synchronised.
//
// The APB interface to the registers is this design's own decision.
`default_nettype none
module timer16 (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// APB slave
	input wire timer16_pkg::apb_req_t apb_i,
	output timer16_pkg::apb_rsp_t apb_o,
	// Pins
	input wire logic capture_input_pin_i,
	input wire logic external_count_pin_i,
	output logic [1:0] compare_output_pins_o,
	output logic [1:0] compare_output_enable_o,
	// Core side
	input wire logic comparator_out_i,
	input wire logic capture_source_comparator_i,
	input wire logic global_irq_enable_i,
	input wire logic [3:0] irq_ack_i,
	output logic [3:0] irq_request_o
);
	import timer16_pkg::*;

	logic [7:0] ctrl_a, ctrl_b, temp, irq_mask, flags;
	logic [15:0] cnt, cmp_a, cmp_b, cap;
	logic [9:0] presc;
	logic cap_s1, cap_s2, ext_s1, ext_s2, ext_s3;
	logic [2:0] hist;
	logic filt, filt_prev, count_up, block;

	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC);
	endfunction
	function automatic logic is_phase(input logic [3:0] m);
		is_phase = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
	endfunction
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
		input logic [15:0] c);
		case (m)
			4'h1, 4'h5: top_of = 16'h00FF;
			4'h2, 4'h6: top_of = 16'h01FF;
			4'h3, 4'h7: top_of = 16'h03FF;
			4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
			4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
			default: top_of = CNT_MAX;
		endcase
	endfunction
	// Next output level; hit is a compare match or a force, edge is the period restart
	function automatic logic oc_next(input logic cur, input logic [1:0] com, input logic hit,
		input logic edge_top, input logic pwm, input logic phase, input logic up,
		input logic tog_ok);
		oc_next = cur;
		if (!pwm) begin
			if (hit) begin
				case (com)
					2'h1: oc_next = ~cur;
					2'h2: oc_next = 1'b0;
					2'h3: oc_next = 1'b1;
					default: oc_next = cur;
				endcase
			end
		end else if (com == 2'h1) begin
			if (hit && tog_ok)
				oc_next = ~cur;
		end else if (com[1]) begin
			if (hit)
				oc_next = (phase && !up) ? ~com[0] : com[0];
			else if (edge_top && !phase)
				oc_next = ~com[0];
		end
	endfunction

	// Bus decode
	logic [7:0] idx, wbyte, rd_mux;
	logic access, wr_fire, rd_fire, hit_map;
	assign idx = apb_i.paddr[9:2];
	assign wbyte = apb_i.pwdata[7:0];
	assign access = apb_i.psel && apb_i.penable;
	assign wr_fire = access && apb_o.pready && apb_i.pwrite && apb_i.pstrb[0];
	assign rd_fire = access && apb_o.pready && !apb_i.pwrite;
	assign hit_map = (idx inside {IDX_FLAGS, IDX_MASK, IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_C,
		IDX_CNT_L, IDX_CNT_H, IDX_CAP_L, IDX_CAP_H, IDX_CMPA_L, IDX_CMPA_H, IDX_CMPB_L,
		IDX_CMPB_H}) && apb_i.paddr[11:10] == 2'h0;

	logic [3:0] mode;
	logic [2:0] cs;
	logic pwm, phase, icr_top, cnt_wr, force_a, force_b;
	logic [15:0] top;
	assign mode = {ctrl_b[4:3], ctrl_a[1:0]};
	assign cs = ctrl_b[2:0];
	assign pwm = is_pwm(mode);
	assign phase = is_phase(mode);
	assign top = top_of(mode, cmp_a, cap);
	assign icr_top = (mode inside {4'h8, 4'hA, 4'hC, 4'hE});
	assign cnt_wr = wr_fire && idx == IDX_CNT_L;
	assign force_a = wr_fire && idx == IDX_CTRL_C && wbyte[B_FOCA] && !pwm;
	assign force_b = wr_fire && idx == IDX_CTRL_C && wbyte[B_FOCB] && !pwm;

	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			IDX_FLAGS: rd_mux = flags & IRQ_BITS_MASK;
			IDX_MASK: rd_mux = irq_mask & IRQ_BITS_MASK;
			IDX_CTRL_A: rd_mux = ctrl_a & CTRL_A_MASK;
			IDX_CTRL_B: rd_mux = ctrl_b & CTRL_B_MASK;
			IDX_CTRL_C: rd_mux = 8'h00;
			IDX_CNT_L: rd_mux = cnt[7:0];
			IDX_CAP_L: rd_mux = cap[7:0];
			IDX_CMPA_L: rd_mux = cmp_a[7:0];
			IDX_CMPB_L: rd_mux = cmp_b[7:0];
			IDX_CNT_H, IDX_CAP_H, IDX_CMPA_H, IDX_CMPB_H: rd_mux = temp;
			default: rd_mux = 8'h00;
		endcase
	end

	// Two-cycle access: pready rises in the first access cycle's following edge
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			apb_o <= '0;
		end else begin
			apb_o.pready <= access && !apb_o.pready;
			apb_o.pslverr <= access && !apb_o.pready && !hit_map;
			if (access && !apb_o.pready)
				apb_o.prdata <= {24'h000000, hit_map ? rd_mux : 8'h00};
		end
	end

	// Shared high-byte latch: high writes park here, low reads fill it
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			temp <= CTRL_RESET;
		end else if (wr_fire && idx inside {IDX_CNT_H, IDX_CAP_H, IDX_CMPA_H, IDX_CMPB_H}) begin
			temp <= wbyte;
		end else if (rd_fire) begin
			case (idx)
				IDX_CNT_L: temp <= cnt[15:8];
				IDX_CAP_L: temp <= cap[15:8];
				IDX_CMPA_L: temp <= cmp_a[15:8];
				IDX_CMPB_L: temp <= cmp_b[15:8];
				default: temp <= temp;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_a <= CTRL_RESET;
			ctrl_b <= CTRL_RESET;
			irq_mask <= CTRL_RESET;
			cmp_a <= WORD_RESET;
			cmp_b <= WORD_RESET;
		end else if (wr_fire) begin
			case (idx)
				IDX_CTRL_A: ctrl_a <= wbyte & CTRL_A_MASK;
				IDX_CTRL_B: ctrl_b <= wbyte & CTRL_B_MASK;
				IDX_MASK: irq_mask <= wbyte & IRQ_BITS_MASK;
				IDX_CMPA_L: cmp_a <= {temp, wbyte};
				IDX_CMPB_L: cmp_b <= {temp, wbyte};
				default: ctrl_a <= ctrl_a;
			endcase
		end
	end

	// Synchronisers; capture uses the second stage, the count edge detector the second and third
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{cap_s1, cap_s2, ext_s1, ext_s2, ext_s3} <= 5'h00;
		end else begin
			cap_s1 <= capture_input_pin_i;
			cap_s2 <= cap_s1;
			ext_s1 <= external_count_pin_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// Prescaler and timer tick
	logic tick;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			presc <= 10'h000;
		else
			presc <= presc + 10'h001;
	end
	always_comb begin
		case (cs)
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (presc & DIV8_MASK) == DIV8_MASK;
			CS_DIV64: tick = (presc & DIV64_MASK) == DIV64_MASK;
			CS_DIV256: tick = (presc & DIV256_MASK) == DIV256_MASK;
			CS_DIV1024: tick = presc == DIV1024_MASK;
			CS_EXT_FALL: tick = ext_s3 && !ext_s2;
			CS_EXT_RISE: tick = !ext_s3 && ext_s2;
			default: tick = 1'b0;
		endcase
	end

	// Capture path with optional four-sample filter
	logic raw, lvl, lvl_prev, cap_event;
	assign raw = capture_source_comparator_i ? comparator_out_i : cap_s2;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hist <= 3'h0;
			filt <= 1'b0;
			filt_prev <= 1'b0;
		end else begin
			hist <= {hist[1:0], raw};
			if ({hist, raw} == 4'hF)
				filt <= 1'b1;
			else if ({hist, raw} == 4'h0)
				filt <= 1'b0;
			filt_prev <= filt;
		end
	end
	assign lvl = ctrl_b[B_NF] ? filt : raw;
	assign lvl_prev = ctrl_b[B_NF] ? filt_prev : hist[0];
	assign cap_event = !icr_top && (ctrl_b[B_CES] ? (lvl && !lvl_prev)
		: (!lvl && lvl_prev));

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			cap <= WORD_RESET;
		else if (cap_event)
			cap <= cnt;
		else if (wr_fire && idx == IDX_CAP_L)
			cap <= {temp, wbyte};
	end

	// Counter
	logic at_top, at_bot, match_a, match_b;
	assign at_top = cnt == top;
	assign at_bot = cnt == WORD_RESET;
	assign match_a = tick && !block && cnt == cmp_a;
	assign match_b = tick && !block && cnt == cmp_b;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= WORD_RESET;
			count_up <= 1'b1;
		end else if (cnt_wr) begin
			cnt <= {temp, wbyte};
		end else if (tick) begin
			// Wrap is driven by the top value, never by a forced match
			if (!phase) begin
				cnt <= at_top ? WORD_RESET : cnt + 16'h0001;
			end else if (count_up) begin
				cnt <= at_top ? cnt - 16'h0001 : cnt + 16'h0001;
				count_up <= !at_top;
			end else begin
				cnt <= at_bot ? cnt + 16'h0001 : cnt - 16'h0001;
				count_up <= at_bot;
			end
		end
	end

	// Blocking persists until the next tick so slow prescales are covered too
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			block <= 1'b0;
		else if (cnt_wr)
			block <= 1'b1;
		else if (tick)
			block <= 1'b0;
	end

	// Flags: hardware set wins over software or acknowledge clear
	logic [7:0] set_f, clr_f;
	always_comb begin
		set_f = 8'h00;
		set_f[B_CAP] = cap_event || (icr_top && tick && at_top);
		set_f[B_CMPA] = match_a;
		set_f[B_CMPB] = match_b;
		set_f[B_OVF] = tick && (pwm ? (phase ? (at_bot && !count_up) : at_top)
			: cnt == CNT_MAX);
		clr_f = {2'h0, irq_ack_i[3], 2'h0, irq_ack_i[2:0]};
		if (wr_fire && idx == IDX_FLAGS)
			clr_f = clr_f | wbyte;
	end
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			flags <= CTRL_RESET;
		else
			flags <= ((flags & ~clr_f) | set_f) & IRQ_BITS_MASK;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_request_o <= 4'h0;
		end else begin
			irq_request_o <= {flags[B_CAP], flags[B_CMPB], flags[B_CMPA], flags[B_OVF]}
				& {irq_mask[B_CAP], irq_mask[B_CMPB], irq_mask[B_CMPA], irq_mask[B_OVF]}
				& {4{global_irq_enable_i}};
		end
	end

	// Waveform outputs
	logic wrap;
	assign wrap = tick && at_top;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			compare_output_pins_o <= 2'h0;
			compare_output_enable_o <= 2'h0;
		end else begin
			compare_output_pins_o[0] <= oc_next(compare_output_pins_o[0], ctrl_a[7:6],
				match_a || force_a, wrap, pwm, phase, count_up,
				mode inside {4'h9, 4'hB, 4'hE, 4'hF});
			compare_output_pins_o[1] <= oc_next(compare_output_pins_o[1], ctrl_a[5:4],
				match_b || force_b, wrap, pwm, phase, count_up, 1'b0);
			compare_output_enable_o <= {ctrl_a[5:4] != 2'h0, ctrl_a[7:6] != 2'h0};
		end
	end

	sequence s_write_then_blocked;
		cnt_wr ##1 block;
	endsequence

	chk_filter_four: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$changed(filt) |-> $past(raw, 1) == filt && $past(raw, 2) == filt
			&& $past(raw, 3) == filt && $past(raw, 4) == filt)
		else $error("filter changed without four equal samples");
	chk_capture_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cap_event |=> cap == $past(cnt) && flags[B_CAP])
		else $error("capture did not load counter or flag");
	chk_capture_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		icr_top && !(wr_fire && idx == IDX_CAP_L) |=> $stable(cap))
		else $error("capture register moved while it is top");
	chk_stopped_cnt: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cs == CS_STOP && !cnt_wr |=> cnt == $past(cnt))
		else $error("counter moved while stopped");
	chk_force_noflag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		force_a && !match_a && !flags[B_CMPA] && !irq_ack_i[1] |=> !flags[B_CMPA])
		else $error("forced compare set a flag");
	chk_write_block: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		s_write_then_blocked |-> !match_a && !match_b)
		else $error("match not blocked after counter write");
	chk_match_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		match_b |=> flags[B_CMPB])
		else $error("compare flag not set after match");
	chk_mask_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		apb_o.pready && !apb_i.pwrite && idx == IDX_MASK |-> apb_o.prdata[7:6] == 2'h0
			&& apb_o.prdata[4:3] == 2'h0)
		else $error("reserved mask bits read nonzero");
	chk_irq_gate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		irq_request_o[0] |-> $past(flags[B_OVF]) && $past(irq_mask[B_OVF])
			&& $past(global_irq_enable_i))
		else $error("overflow request without enable and flag");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the 16-bit timer: register map, byte latch, clocking, capture, compare.
// Assumes timer16_pkg and timer16; drives APB and all pins directly on mclk_i rising edges.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer16_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic cap = 1'b1;
	logic ext = 1'b0;
	logic comp = 1'b1;
	logic csrc = 1'b0;
	logic glob = 1'b0;
	logic [3:0] ack = 4'h0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [1:0] pins;
	logic [1:0] oen;
	logic [3:0] irq;
	logic [7:0] rdv;
	logic erv;
	logic [15:0] v16;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int divs [6] = '{0, 1, 8, 64, 256, 1024};
	// Index, write value, expected read-back
	// Reserved bit 5 of control B is always written as zero; the strobes read back as zero
	logic [23:0] rows [7] = '{{IDX_CTRL_B, 8'hDF, 8'hDF}, {IDX_MASK, 8'hFF, 8'h27},
		{IDX_CTRL_A, 8'hFF, 8'hF3}, {IDX_CTRL_B, 8'h00, 8'h00}, {IDX_MASK, 8'h00, 8'h00},
		{IDX_CTRL_A, 8'h00, 8'h00}, {IDX_CTRL_C, 8'hC0, 8'h00}};

	timer16 u_dut (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.apb_i(req),
		.apb_o(rsp),
		.capture_input_pin_i(cap),
		.external_count_pin_i(ext),
		.compare_output_pins_o(pins),
		.compare_output_enable_o(oen),
		.comparator_out_i(comp),
		.capture_source_comparator_i(csrc),
		.global_irq_enable_i(glob),
		.irq_ack_i(ack),
		.irq_request_o(irq)
	);

	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		// Longest legal run is the /1024 prescaler case, well below this
		if (cycles == 60000) begin
			err_count++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One idle edge before setup keeps release and next setup in separate time steps
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge mclk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00},
			pwdata: {24'h000000, wd}, pstrb: 4'hF};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
		end
		rdv = rsp.prdata[7:0];
		erv = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic w16(input logic [7:0] lo, input logic [15:0] v);
		xfer(1'b1, lo + 8'h01, v[15:8]);
		xfer(1'b1, lo, v[7:0]);
	endtask

	task automatic r16(input logic [7:0] lo);
		xfer(1'b0, lo, 8'h00);
		v16[7:0] = rdv;
		xfer(1'b0, lo + 8'h01, 8'h00);
		v16[15:8] = rdv;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic rflags();
		xfer(1'b0, IDX_FLAGS, 8'h00);
	endtask

	// Rising capture from a known counter start; the filter only shifts the captured value
	task automatic cap_run(input logic nf);
		cap <= 1'b0;
		xfer(1'b1, IDX_CTRL_B, 8'h00);
		w16(IDX_CNT_L, 16'h0000);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		xfer(1'b1, IDX_CTRL_B, {nf, 7'h41});
		cyc(10);
		cap <= 1'b1;
		cyc(20);
		xfer(1'b1, IDX_CTRL_B, 8'h00);
		r16(IDX_CAP_L);
	endtask

	initial begin
		logic [15:0] base;
		cyc(10);
		resetn_i <= 1'b1;
		xfer(1'b0, IDX_CTRL_B, 8'h00);
		chk("ctrl_b reset", rdv, 16'h0000);
		r16(IDX_CMPB_L);
		chk("cmp_b reset", v16, 16'h0000);
		xfer(1'b0, 8'h00, 8'h00);
		chk("unmapped error", erv, 16'h0001);
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, rows[i][23:16], rows[i][15:8]);
			xfer(1'b0, rows[i][23:16], 8'h00);
			chk("readback", rdv, rows[i][7:0]);
		end
		w16(IDX_CMPB_L, 16'hA55A);
		w16(IDX_CNT_L, 16'h0ABC);
		r16(IDX_CMPB_L);
		chk("cmp_b pair", v16, 16'hA55A);
		r16(IDX_CNT_L);
		chk("counter pair", v16, 16'h0ABC);
		// Edge select: rising ignored with select zero, falling captures
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		cap <= 1'b0;
		cyc(8);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		cap <= 1'b1;
		cyc(8);
		rflags();
		chk("no rising capture", rdv & 8'h20, 16'h0000);
		cap <= 1'b0;
		cyc(8);
		rflags();
		chk("falling capture flag", rdv & 8'h20, 16'h0020);
		r16(IDX_CAP_L);
		chk("capture value", v16, 16'h0ABC);
		xfer(1'b1, IDX_FLAGS, 8'h20);
		rflags();
		chk("flag write one", rdv & 8'h20, 16'h0000);
		csrc <= 1'b1;
		cyc(4);
		comp <= 1'b0;
		cyc(8);
		rflags();
		chk("comparator capture", rdv & 8'h20, 16'h0020);
		csrc <= 1'b0;
		cap_run(1'b0);
		base = v16;
		cap_run(1'b1);
		chk("filter delay", v16 - base, 16'(FILTER_DELAY));
		// Filter on, falling edge select: only the long low pulse survives
		xfer(1'b1, IDX_CTRL_B, 8'h80);
		for (int g = 2; g <= 6; g += 4) begin
			xfer(1'b1, IDX_FLAGS, 8'hFF);
			cap <= 1'b0;
			cyc(g);
			cap <= 1'b1;
			cyc(12);
			rflags();
			chk("filtered pulse", rdv & 8'h20, g == 6 ? 16'h0020 : 16'h0000);
		end
		// Capture register as top: the pin is disconnected
		xfer(1'b1, IDX_CTRL_B, 8'h18);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		cap <= 1'b0;
		cyc(8);
		rflags();
		chk("capture disabled", rdv & 8'h20, 16'h0000);
		xfer(1'b1, IDX_CTRL_B, 8'h00);
		for (int i = 0; i < 6; i++) begin
			w16(IDX_CNT_L, 16'h0000);
			xfer(1'b1, IDX_CTRL_B, {5'h00, 3'(i)});
			cyc(20 * (i == 0 ? 1 : divs[i]));
			xfer(1'b1, IDX_CTRL_B, 8'h00);
			r16(IDX_CNT_L);
			chk("prescaled count", (i == 0) ? v16 : 16'(v16 >= 19 && v16 <= 26),
				(i == 0) ? 16'h0000 : 16'h0001);
		end
		for (int c = 7; c >= 6; c--) begin
			w16(IDX_CNT_L, 16'h0000);
			xfer(1'b1, IDX_CTRL_B, {5'h00, 3'(c)});
			repeat (5) begin
				ext <= 1'b1;
				cyc(4);
				ext <= 1'b0;
				cyc(4);
			end
			cyc(4);
			xfer(1'b1, IDX_CTRL_B, 8'h00);
			r16(IDX_CNT_L);
			chk("pin count", v16, 16'h0005);
		end
		// Compare match, interrupt gating and vector acknowledge
		w16(IDX_CMPA_L, 16'h0010);
		w16(IDX_CNT_L, 16'h0000);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		xfer(1'b1, IDX_MASK, 8'h02);
		glob <= 1'b1;
		xfer(1'b1, IDX_CTRL_B, 8'h01);
		cyc(40);
		xfer(1'b1, IDX_CTRL_B, 8'h00);
		rflags();
		chk("compare a flag", rdv & 8'h02, 16'h0002);
		chk("irq a on", irq[1], 16'h0001);
		glob <= 1'b0;
		cyc(3);
		chk("irq a global off", irq[1], 16'h0000);
		ack <= 4'h2;
		cyc(1);
		ack <= 4'h0;
		rflags();
		chk("ack clears flag", rdv & 8'h02, 16'h0000);
		// Counter write while running hides the match on the next tick
		w16(IDX_CMPB_L, 16'h0005);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		xfer(1'b1, IDX_CTRL_B, 8'h01);
		w16(IDX_CNT_L, 16'h0005);
		xfer(1'b1, IDX_CTRL_B, 8'h00);
		rflags();
		chk("blocked match", rdv & 8'h04, 16'h0000);
		// Clear on match with compare A as top: a force must not clear the counter
		w16(IDX_CNT_L, 16'h0100);
		xfer(1'b1, IDX_FLAGS, 8'hFF);
		xfer(1'b1, IDX_CTRL_B, 8'h08);
		xfer(1'b1, IDX_CTRL_A, 8'hF0);
		xfer(1'b1, IDX_CTRL_C, 8'hC0);
		cyc(2);
		chk("forced set", pins, 16'h0003);
		chk("output enable", oen, 16'h0003);
		rflags();
		chk("force no flag", rdv, 16'h0000);
		r16(IDX_CNT_L);
		chk("force keeps counter", v16, 16'h0100);
		// Fast PWM, clear on match: a strobe here must be ignored
		xfer(1'b1, IDX_CTRL_B, 8'h08);
		xfer(1'b1, IDX_CTRL_A, 8'h81);
		xfer(1'b1, IDX_CTRL_C, 8'h80);
		cyc(2);
		chk("pwm force ignored", pins[0], 16'h0001);
		xfer(1'b1, IDX_CTRL_C, 8'h00);
		chk("pwm output enable", oen, 16'h0001);
		// Reset in mid-run: outputs and control registers return to zero
		resetn_i <= 1'b0;
		cyc(2);
		chk("reset pins", pins, 16'h0000);
		chk("reset irq", irq, 16'h0000);
		resetn_i <= 1'b1;
		xfer(1'b0, IDX_CTRL_B, 8'h00);
		chk("ctrl_b mid reset", rdv, 16'h0000);
		xfer(1'b0, IDX_CTRL_A, 8'h00);
		chk("ctrl_a mid reset", rdv, 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
